// File: common/hub_cfg_pkg.sv
// constants, field layouts, defaults and states of the hub configuration and power-mode logic
// assumes a single 100 MHz clock and an active-low asynchronous chip reset
// Summary of operation
// - select pins picked once after reset release
// - multi mode: one translator per port, four buffers
// - vendor id loaded, or built-in default
// - product id loaded, or built-in default
// - bcd release loaded, or built-in default
// - internal defaults: power mode from detect pin
// - speed disable forces full speed only
// - single or per-port translator; host forces single only
// - eop at frame point only in full speed
// - sensing per port/ganged/none; internal follows power
// - power ganged or per port; strap under internal
// - strapped fixed ports imply compound device
// - fixed-device ports from two strap pins under internal, else loaded
// - separate disable masks, contiguous down from three
// - internal defaults: disable strap disables port 3
// - dynamic switching follows local power detect
// - power change: drop all, detach, reattach
// - over-current reported after delay in 2 ms steps
// - power and current fields per mode, 2 mA
// - power-on time reported in 2 ms units
// - switch polarity chosen by strap only
// - no pull-up without upstream vbus sensed
// - detect pin high means local power present
package hub_cfg_pkg;
  // configuration image byte indices
  localparam logic [3:0] IDX_VID_LO = 4'h0;
  localparam logic [3:0] IDX_VID_HI = 4'h1;
  localparam logic [3:0] IDX_PID_LO = 4'h2;
  localparam logic [3:0] IDX_PID_HI = 4'h3;
  localparam logic [3:0] IDX_DID_LO = 4'h4;
  localparam logic [3:0] IDX_DID_HI = 4'h5;
  localparam logic [3:0] IDX_CFG1 = 4'h6;
  localparam logic [3:0] IDX_CFG2 = 4'h7;
  localparam logic [3:0] IDX_NONREM = 4'h8;
  localparam logic [3:0] IDX_PDIS_SELF = 4'h9;
  localparam logic [3:0] IDX_PDIS_BUS = 4'hA;
  localparam logic [3:0] IDX_MAXP_SELF = 4'hB;
  localparam logic [3:0] IDX_MAXP_BUS = 4'hC;
  localparam logic [3:0] IDX_HCC_SELF = 4'hD;
  localparam logic [3:0] IDX_HCC_BUS = 4'hE;
  localparam logic [3:0] IDX_PON = 4'hF;
  // config byte 1 fields
  localparam int B1_LOCAL_POWER_DETECT = 7;
  localparam int B1_HS_DISABLE = 5;
  localparam int B1_MULTI_TT = 4;
  localparam int B1_EOP_EN = 3;
  localparam int B1_SENSE_HI = 2;
  localparam int B1_SENSE_LO = 1;
  localparam int B1_GANG_PWR = 0;
  // config byte 2 fields
  localparam int B2_DYNAMIC = 7;
  localparam int B2_OCT_HI = 5;
  localparam int B2_OCT_LO = 4;
  localparam int B2_COMPOUND = 3;
  // sensing modes
  localparam logic [1:0] SENSE_NONE = 2'h0;
  localparam logic [1:0] SENSE_GANGED = 2'h1;
  localparam logic [1:0] SENSE_PER_PORT = 2'h2;
  // default image bytes
  localparam logic [7:0] DEF_CFG1 = 8'h98;
  localparam logic [7:0] DEF_CFG2 = 8'h90;
  localparam logic [7:0] DEF_MAXP_SELF = 8'h01;
  localparam logic [7:0] DEF_MAXP_BUS = 8'h64;
  localparam logic [7:0] DEF_HCC_SELF = 8'h01;
  localparam logic [7:0] DEF_HCC_BUS = 8'h64;
  localparam logic [7:0] DEF_PON = 8'h32;
  localparam logic [15:0] DEF_DID = 16'h0000;
  // register map of the management port
  localparam logic [7:0] REG_IMAGE_LAST = 8'h3C;
  localparam logic [7:0] REG_CTRL = 8'h40;
  localparam logic [7:0] REG_STATUS = 8'h44;
  localparam int CTRL_LOAD_DONE = 0;
  // translator figures
  localparam logic [1:0] TT_MULTI = 2'h3;
  localparam logic [1:0] TT_SINGLE = 2'h1;
  localparam logic [2:0] NONPER_BUFS = 3'h4;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int OC_STEP_MS = 2;
  localparam int OC_STEP_CYCLES = OC_STEP_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] SETTLE_LAST = 2'h2;
  localparam int VBUS_DROP_MAX_S = 10;
  // sources and states
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_MGMT, SRC_EEPROM} cfg_source_e;
  typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN, ST_SWITCH} ctrl_state_e;
  // default image after reset
  function automatic logic [7:0] default_byte(input logic [3:0] idx);
    case (idx)
      IDX_CFG1: default_byte = DEF_CFG1;
      IDX_CFG2: default_byte = DEF_CFG2;
      IDX_MAXP_SELF: default_byte = DEF_MAXP_SELF;
      IDX_MAXP_BUS: default_byte = DEF_MAXP_BUS;
      IDX_HCC_SELF: default_byte = DEF_HCC_SELF;
      IDX_HCC_BUS: default_byte = DEF_HCC_BUS;
      IDX_PON: default_byte = DEF_PON;
      default: default_byte = 8'h00;
    endcase
  endfunction : default_byte
endpackage : hub_cfg_pkg

// File: common/oc_if.sv
// carrier between the controller and the over-current filter
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface oc_if;
  logic tick;         // 2 ms step pulse
  logic [1:0] delay;  // persistence in steps
  logic [2:0] oc_raw; // synchronised sense, ports 1..3
  logic [2:0] oc_flag; // filtered report
  modport ctrl (output tick, output delay, output oc_raw, input oc_flag);
  modport filt (input tick, input delay, input oc_raw, output oc_flag);
endinterface : oc_if
`default_nettype wire

// File: verif/ee_image_source.sv
// far-side eeprom source: streams one fixed 16-byte image into the hub
// assumes the hub takes one byte per cycle while it is loading
`timescale 1ns/1ns
`default_nettype none
module ee_image_source (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // start pulse from the bench
  input wire logic start_i,
  // byte stream towards the hub
  output logic ee_valid_o,
  output logic [3:0] ee_index_o,
  output logic [7:0] ee_data_o,
  output logic ee_done_o
);
  logic [4:0] cnt_reg; // 17 down to 1: sixteen bytes, then the end mark
  // load counter, restarted by the bench
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 5'h00;
    end else if (start_i) begin
      cnt_reg <= 5'h11;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
  assign ee_index_o = 4'(5'h11 - cnt_reg);
  assign ee_valid_o = (cnt_reg > 5'h01);
  // data line is inverted when idle so a stale byte never looks valid
  assign ee_data_o = ee_valid_o ? {ee_index_o, ~ee_index_o} : {~ee_index_o, ee_index_o};
  assign ee_done_o = (cnt_reg == 5'h01);
endmodule : ee_image_source
`default_nettype wire

// File: verif/tb_top.sv
// bench: internal, management and eeprom sources, dynamic power, over-current
// assumes a 100 MHz clock and a 20-cycle over-current step
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hub_cfg_pkg::*;
  logic clk_i, nrst_i, config_source_select_hi_i, config_source_select_lo_i, start;
  logic local_power_detect_i, power_gang_strap_i, port_disable_strap_i, switch_polarity_strap_i;
  logic upstream_vbus_sense_i, reg_wr_i, reg_rd_i, host_single_tt_i, link_full_speed_i;
  logic ee_valid_i, ee_done_i, self_powered_o, full_speed_only_o, eop_at_eof1_en_o;
  logic gang_power_o, compound_o, upstream_connect_o, pullup_enable_o, config_done_o;
  logic [1:0] fixed_device_port_strap_i, tt_count_o, sense_mode_o;
  logic [2:0] oc_sense_i, port_power_req_i, tt_nonper_bufs_o, non_removable_o, port_disabled_o;
  logic [2:0] oc_report_o, port_power_switch_out_o;
  logic [3:0] ee_index_i;
  logic [7:0] reg_addr_i, ee_data_i, max_power_o, hc_current_o, power_on_time_o;
  logic [15:0] vendor_id_o, product_id_o, release_bcd_o;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  int n_fail, num_checks;
  // identity defaults are arbitrary values
  hub_config_power_mode_ctrl #(.VID_DEFAULT(16'h1111), .PID_DEFAULT(16'h2222), .STEP_CYCLES(20))
  i_hub_config_power_mode_ctrl (.clk_i, .nrst_i, .config_source_select_hi_i,
    .config_source_select_lo_i, .local_power_detect_i, .power_gang_strap_i,
    .fixed_device_port_strap_i, .port_disable_strap_i, .switch_polarity_strap_i,
    .upstream_vbus_sense_i, .oc_sense_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .ee_valid_i, .ee_index_i, .ee_data_i, .ee_done_i, .host_single_tt_i,
    .link_full_speed_i, .port_power_req_i, .vendor_id_o, .product_id_o, .release_bcd_o,
    .self_powered_o, .full_speed_only_o, .tt_count_o, .tt_nonper_bufs_o, .eop_at_eof1_en_o,
    .sense_mode_o, .gang_power_o, .compound_o, .non_removable_o, .port_disabled_o,
    .max_power_o, .hc_current_o, .power_on_time_o, .oc_report_o, .port_power_switch_out_o,
    .upstream_connect_o, .pullup_enable_o, .config_done_o);
  ee_image_source i_ee_image_source (.clk_i, .nrst_i, .start_i(start), .ee_valid_o(ee_valid_i),
    .ee_index_o(ee_index_i), .ee_data_o(ee_data_i), .ee_done_o(ee_done_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // select pins and polarity held steady across the reset release
  task automatic boot(input logic [1:0] sel, input logic pol);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    {config_source_select_hi_i, config_source_select_lo_i} <= sel;
    switch_polarity_strap_i <= pol;
    cyc(4);
    @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask : boot
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data is looked at just after the edge that loads it; it holds until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
  endtask : rd
  // bounded wait for the run state
  task automatic wait_done;
    for (int i = 0; i < 100 && config_done_o !== 1'b1; i++) cyc(1);
    if (config_done_o !== 1'b1) begin
      n_fail++;
      report_and_stop;
    end
    cyc(2);
  endtask : wait_done
  initial begin
    // reset low; self power, ganged, port 3 disabled, vbus up
    {nrst_i, config_source_select_hi_i, config_source_select_lo_i, local_power_detect_i,
      power_gang_strap_i, port_disable_strap_i, switch_polarity_strap_i, upstream_vbus_sense_i,
      reg_wr_i, reg_rd_i, host_single_tt_i, link_full_speed_i, start} = 13'h03E0;
    {fixed_device_port_strap_i, oc_sense_i, port_power_req_i} = 8'h80;
    {reg_addr_i, reg_wdata_i} = 40'h00_0000_0000;
    boot(2'h0, 1'b1);
    wait_done;
    chk(vendor_id_o, 16'h1111);
    chk(product_id_o, 16'h2222);
    chk(release_bcd_o, DEF_DID);
    chk({self_powered_o, sense_mode_o, gang_power_o}, {1'b1, SENSE_GANGED, 1'b1});
    chk({compound_o, non_removable_o, port_disabled_o}, 7'h5C);
    chk({max_power_o, power_on_time_o}, {DEF_MAXP_SELF, DEF_PON});
    chk({tt_count_o, tt_nonper_bufs_o}, {TT_MULTI, NONPER_BUFS});
    chk({eop_at_eof1_en_o, full_speed_only_o, pullup_enable_o}, 3'h1);
    @(posedge clk_i) port_power_req_i <= 3'h7;
    host_single_tt_i <= 1'b1;
    cyc(4);
    // port 3 stays off: the disable strap outranks the request
    chk({port_power_switch_out_o, tt_count_o}, {3'h3, TT_SINGLE});
    @(posedge clk_i) local_power_detect_i <= 1'b0;
    cyc(6);
    chk({upstream_connect_o, port_power_switch_out_o}, 4'h0);
    cyc(25);
    chk({upstream_connect_o, self_powered_o, sense_mode_o}, {2'h2, SENSE_NONE});
    chk(max_power_o, DEF_MAXP_BUS);
    @(posedge clk_i) upstream_vbus_sense_i <= 1'b0;
    cyc(6);
    chk(pullup_enable_o, 1'b0);
    $display("test internal done");
    @(posedge clk_i) {port_power_req_i, host_single_tt_i} <= 4'h0;
    boot(2'h1, 1'b0);
    cyc(6);
    wr(8'h00, 32'h0000_0034);
    wr(8'h04, 32'h0000_0012);
    wr(8'h18, 32'h0000_0024);
    wr(8'h1C, 32'h0000_0010);
    rd(8'h18);
    chk(reg_rdata_o, 32'h0000_0024);
    rd(8'h80);
    chk(reg_rdata_o, 32'h0000_0000);
    rd(8'h44);
    chk(reg_rdata_o[3:0], {2'h1, SRC_MGMT});
    wr(8'h40, 32'h0000_0001);
    wait_done;
    chk({vendor_id_o, full_speed_only_o, self_powered_o}, {16'h1234, 2'h2});
    chk({port_power_switch_out_o, tt_count_o}, {3'h7, TT_SINGLE});
    @(posedge clk_i) {port_power_req_i, oc_sense_i} <= 6'h09;
    cyc(8);
    chk(oc_report_o, 3'h0);
    cyc(40);
    chk({oc_report_o, port_power_switch_out_o}, 6'h0E);
    $display("test management done");
    @(posedge clk_i) {port_power_req_i, oc_sense_i, link_full_speed_i} <= 7'h01;
    boot(2'h2, 1'b1);
    cyc(6);
    @(posedge clk_i);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    wait_done;
    chk({vendor_id_o, product_id_o}, 32'h1E0F_3C2D);
    chk(release_bcd_o, 16'h5A4B);
    chk({full_speed_only_o, eop_at_eof1_en_o, self_powered_o}, 3'h6);
    chk({max_power_o, hc_current_o, power_on_time_o}, 24'hC3_E1F0);
    $display("test eeprom done");
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire

// File: verilog/hub_config_power_mode_ctrl.sv
// configuration source selection, field application and power-mode control
// assumes pins come from other domains; loader and hub core share clk_i
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module hub_config_power_mode_ctrl #(
  parameter logic [15:0] VID_DEFAULT = 16'h0001, // arbitrary value
  parameter logic [15:0] PID_DEFAULT = 16'h0002, // arbitrary value
  parameter int STEP_CYCLES = hub_cfg_pkg::OC_STEP_CYCLES,
  parameter int REATTACH_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // strap and sense pins
  input wire logic config_source_select_hi_i,
  input wire logic config_source_select_lo_i,
  input wire logic local_power_detect_i,
  input wire logic power_gang_strap_i,
  input wire logic [1:0] fixed_device_port_strap_i,
  input wire logic port_disable_strap_i,
  input wire logic switch_polarity_strap_i,
  input wire logic upstream_vbus_sense_i,
  input wire logic [2:0] oc_sense_i,
  // management register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // eeprom loader stream
  input wire logic ee_valid_i,
  input wire logic [3:0] ee_index_i,
  input wire logic [7:0] ee_data_i,
  input wire logic ee_done_i,
  // hub core requests
  input wire logic host_single_tt_i,
  input wire logic link_full_speed_i,
  input wire logic [2:0] port_power_req_i,
  // identity and options
  output logic [15:0] vendor_id_o,
  output logic [15:0] product_id_o,
  output logic [15:0] release_bcd_o,
  output logic self_powered_o,
  output logic full_speed_only_o,
  output logic [1:0] tt_count_o,
  output logic [2:0] tt_nonper_bufs_o,
  output logic eop_at_eof1_en_o,
  output logic [1:0] sense_mode_o,
  output logic gang_power_o,
  output logic compound_o,
  output logic [2:0] non_removable_o,
  output logic [2:0] port_disabled_o,
  output logic [7:0] max_power_o,
  output logic [7:0] hc_current_o,
  output logic [7:0] power_on_time_o,
  // power and attach
  output logic [2:0] oc_report_o,
  output logic [2:0] port_power_switch_out_o,
  output logic upstream_connect_o,
  output logic pullup_enable_o,
  output logic config_done_o
);
  import hub_cfg_pkg::*;

  // pin synchronisers
  logic [11:0] pin_meta_reg; // first stage, read only by second
  logic [11:0] pin_sync_reg; // second stage
  logic sel_lo, sel_hi, lp_det, gang_pin, pdis_pin, pol_pin, vbus;
  logic [1:0] fixed_pin;
  logic [2:0] oc_pin;

  // control state
  ctrl_state_e state_reg;
  logic [1:0] settle_cnt_reg;      // edges until synchronisers hold pins
  cfg_source_e source_reg;        // chosen once per reset
  logic gang_strap_reg, pdis_strap_reg, pol_strap_reg;
  logic [1:0] fixed_strap_reg;
  logic self_mode_reg;            // current power mode
  logic [15:0] switch_cnt_reg;    // detach hold time
  logic [7:0] cfg_mem [16];       // configuration image
  logic [$clog2(STEP_CYCLES)-1:0] step_cnt_reg;
  logic step_tick;

  // derived fields
  logic internal, dynamic_en, connected, hs_dis, lp_change;
  logic [7:0] cfg1, cfg2;
  logic [2:0] nonrem_next, pdis_next, power_on;
  logic [1:0] sense_next;
  logic gang_next;

  oc_if oc ();

  // two stages ahead of any logic
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_reg <= 12'h000;
      pin_sync_reg <= 12'h000;
    end else begin
      pin_meta_reg <= {oc_sense_i, upstream_vbus_sense_i, switch_polarity_strap_i,
                       port_disable_strap_i, fixed_device_port_strap_i, power_gang_strap_i,
                       local_power_detect_i, config_source_select_hi_i,
                       config_source_select_lo_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign {oc_pin, vbus, pol_pin, pdis_pin, fixed_pin, gang_pin, lp_det, sel_hi, sel_lo} =
    pin_sync_reg;

  // select pins to source; both-high falls back to defaults
  function automatic cfg_source_e decode_source(input logic hi, input logic lo);
    case ({hi, lo})
      2'b01: decode_source = SRC_MGMT;
      2'b10: decode_source = SRC_EEPROM;
      default: decode_source = SRC_INTERNAL;
    endcase
  endfunction : decode_source

  // disabled ports must run down from port 3 without holes
  function automatic logic [2:0] contiguous(input logic [2:0] m);
    contiguous = {m[2], m[2] & m[1], m[2] & m[1] & m[0]};
  endfunction : contiguous

  assign internal = (source_reg == SRC_INTERNAL);
  assign cfg1 = cfg_mem[IDX_CFG1];
  assign cfg2 = cfg_mem[IDX_CFG2];
  assign dynamic_en = cfg2[B2_DYNAMIC];
  assign connected = (state_reg == ST_RUN);
  assign lp_change = dynamic_en && (lp_det != self_mode_reg);

  // sequencing from reset to attach
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_SETTLE;
      settle_cnt_reg <= 2'h0;
      switch_cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_SETTLE: begin
          settle_cnt_reg <= settle_cnt_reg + 2'h1;
          if (settle_cnt_reg == SETTLE_LAST) begin
            // straps alone need no loading phase
            state_reg <= (decode_source(sel_hi, sel_lo) == SRC_INTERNAL) ? ST_RUN : ST_LOAD;
          end
        end
        ST_LOAD: begin
          if ((source_reg == SRC_MGMT && reg_wr_i && reg_addr_i == REG_CTRL &&
               reg_wdata_i[CTRL_LOAD_DONE]) || (source_reg == SRC_EEPROM && ee_done_i)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (lp_change) begin
            state_reg <= ST_SWITCH;
            switch_cnt_reg <= 16'h0000;
          end
        end
        ST_SWITCH: begin
          switch_cnt_reg <= switch_cnt_reg + 16'h0001;
          if (switch_cnt_reg == 16'(REATTACH_CYCLES - 1)) state_reg <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      source_reg <= SRC_INTERNAL;
      gang_strap_reg <= 1'b0;
      pdis_strap_reg <= 1'b0;
      pol_strap_reg <= 1'b1;
      fixed_strap_reg <= 2'h0;
    end else if (state_reg == ST_SETTLE && settle_cnt_reg == SETTLE_LAST) begin
      source_reg <= decode_source(sel_hi, sel_lo);
      gang_strap_reg <= gang_pin;
      pdis_strap_reg <= pdis_pin;
      pol_strap_reg <= pol_pin;
      fixed_strap_reg <= fixed_pin;
    end
  end

  // power mode taken whenever the hub (re)attaches
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      self_mode_reg <= 1'b0;
    end else if (state_reg != ST_RUN && state_reg != ST_LOAD) begin
      // pin decides under defaults or dynamic mode
      self_mode_reg <= (internal || dynamic_en) ? lp_det : cfg1[B1_LOCAL_POWER_DETECT];
    end else if (state_reg == ST_LOAD) begin
      self_mode_reg <= dynamic_en ? lp_det : cfg1[B1_LOCAL_POWER_DETECT];
    end
  end

  // image written by the chosen external source only while loading
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 16; i++) cfg_mem[i] <= default_byte(4'(i));
    end else if (state_reg == ST_LOAD) begin
      if (source_reg == SRC_MGMT && reg_wr_i && reg_addr_i <= REG_IMAGE_LAST &&
          reg_addr_i[1:0] == 2'b00) begin
        cfg_mem[reg_addr_i[5:2]] <= reg_wdata_i[7:0];
      end else if (source_reg == SRC_EEPROM && ee_valid_i) begin
        cfg_mem[ee_index_i] <= ee_data_i;
      end
    end
  end

  // register read path, data one cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i <= REG_IMAGE_LAST && reg_addr_i[1:0] == 2'b00) begin
        reg_rdata_o <= {24'h00_0000, cfg_mem[reg_addr_i[5:2]]};
      end else if (reg_addr_i == REG_CTRL) begin
        reg_rdata_o <= {31'h0000_0000, config_done_o};
      end else if (reg_addr_i == REG_STATUS) begin
        reg_rdata_o <= {23'h00_0000, oc_report_o, pullup_enable_o, self_mode_reg,
                        2'(state_reg), 2'(source_reg)};
      end else begin
        reg_rdata_o <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // 2 ms step divider
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_cnt_reg <= '0;
    end else if (step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end
  assign step_tick = (step_cnt_reg == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));

  assign oc.tick = step_tick;
  assign oc.delay = cfg2[B2_OCT_HI:B2_OCT_LO];
  assign oc.oc_raw = oc_pin & power_on;
  oc_delay_filter u_oc_filter (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .oc(oc)
  );

  // field selection between loaded image and strap defaults
  always_comb begin
    hs_dis = cfg1[B1_HS_DISABLE];
    sense_next = internal ? (self_mode_reg ? SENSE_GANGED : SENSE_NONE)
                          : cfg1[B1_SENSE_HI:B1_SENSE_LO];
    gang_next = internal ? gang_strap_reg : cfg1[B1_GANG_PWR];
    // strap count of fixed ports from port 1
    nonrem_next = internal ? (3'b111 >> (2'h3 - fixed_strap_reg))
                           : cfg_mem[IDX_NONREM][3:1];
    pdis_next = internal ? {pdis_strap_reg, 2'b00}
              : (self_mode_reg ? cfg_mem[IDX_PDIS_SELF][3:1] : cfg_mem[IDX_PDIS_BUS][3:1]);
    pdis_next = contiguous(pdis_next);
    power_on = connected ? ((gang_next ? {3{|port_power_req_i}} : port_power_req_i) &
                            ~pdis_next) : 3'b000;
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vendor_id_o <= 16'h0000;
      product_id_o <= 16'h0000;
      release_bcd_o <= 16'h0000;
      self_powered_o <= 1'b0;
      full_speed_only_o <= 1'b0;
      tt_count_o <= TT_SINGLE;
      tt_nonper_bufs_o <= NONPER_BUFS;
      eop_at_eof1_en_o <= 1'b0;
      sense_mode_o <= SENSE_NONE;
      gang_power_o <= 1'b0;
      compound_o <= 1'b0;
      non_removable_o <= 3'b000;
      port_disabled_o <= 3'b000;
      max_power_o <= 8'h00;
      hc_current_o <= 8'h00;
      power_on_time_o <= 8'h00;
      oc_report_o <= 3'b000;
      port_power_switch_out_o <= 3'b000;
      upstream_connect_o <= 1'b0;
      pullup_enable_o <= 1'b0;
      config_done_o <= 1'b0;
    end else begin
      vendor_id_o <= internal ? VID_DEFAULT : {cfg_mem[IDX_VID_HI], cfg_mem[IDX_VID_LO]};
      product_id_o <= internal ? PID_DEFAULT : {cfg_mem[IDX_PID_HI], cfg_mem[IDX_PID_LO]};
      release_bcd_o <= internal ? DEF_DID : {cfg_mem[IDX_DID_HI], cfg_mem[IDX_DID_LO]};
      self_powered_o <= self_mode_reg;
      full_speed_only_o <= hs_dis;
      tt_count_o <= (cfg1[B1_MULTI_TT] && !host_single_tt_i) ? TT_MULTI : TT_SINGLE;
      tt_nonper_bufs_o <= NONPER_BUFS;
      eop_at_eof1_en_o <= cfg1[B1_EOP_EN] && (hs_dis || link_full_speed_i);
      sense_mode_o <= sense_next;
      gang_power_o <= gang_next;
      compound_o <= internal ? (|nonrem_next) : cfg2[B2_COMPOUND];
      non_removable_o <= nonrem_next;
      port_disabled_o <= pdis_next;
      max_power_o <= self_mode_reg ? cfg_mem[IDX_MAXP_SELF] : cfg_mem[IDX_MAXP_BUS];
      hc_current_o <= self_mode_reg ? cfg_mem[IDX_HCC_SELF] : cfg_mem[IDX_HCC_BUS];
      // power-on time in 2 ms units
      power_on_time_o <= cfg_mem[IDX_PON];
      oc_report_o <= oc.oc_flag;
      port_power_switch_out_o <= pol_strap_reg ? power_on : ~power_on;
      upstream_connect_o <= connected;
      pullup_enable_o <= connected && vbus;
      config_done_o <= connected || (state_reg == ST_SWITCH);
    end
  end

  a_source_held: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg != ST_SETTLE |=> $stable(source_reg))
    else $error("configuration source changed after selection");
  a_mtt_forced: assert property (@(posedge clk_i) disable iff (!nrst_i)
    host_single_tt_i |=> tt_count_o == TT_SINGLE)
    else $error("host could not force single translator");
  a_vid_default: assert property (@(posedge clk_i) disable iff (!nrst_i)
    internal |=> vendor_id_o == VID_DEFAULT)
    else $error("vendor id not default under internal source");
  a_eop_fs_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !hs_dis && !link_full_speed_i |=> !eop_at_eof1_en_o)
    else $error("eop enabled outside full speed");
  a_disable_contig: assert property (@(posedge clk_i) disable iff (!nrst_i)
    port_disabled_o[0] |-> port_disabled_o[1] && port_disabled_o[2])
    else $error("disabled ports not contiguous");
  a_change_detach: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == ST_RUN && lp_change |=> ##1 !upstream_connect_o && !pullup_enable_o
    && port_power_switch_out_o == (pol_strap_reg ? 3'b000 : 3'b111))
    else $error("power change did not drop power and detach");
  a_reattach_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(state_reg == ST_SWITCH) |-> ##[1:64] state_reg == ST_RUN)
    else $error("hub did not reattach after power change");
  a_pullup_vbus: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !vbus |=> !pullup_enable_o)
    else $error("pull-up powered without vbus");
  a_internal_sense: assert property (@(posedge clk_i) disable iff (!nrst_i)
    internal && !self_mode_reg |=> sense_mode_o == SENSE_NONE)
    else $error("bus-powered default sensing not none");
  c_mgmt_load: cover property (@(posedge clk_i) disable iff (!nrst_i)
    source_reg == SRC_MGMT && state_reg == ST_LOAD ##1 state_reg == ST_RUN);
  c_eeprom_load: cover property (@(posedge clk_i) disable iff (!nrst_i)
    source_reg == SRC_EEPROM && state_reg == ST_LOAD ##1 state_reg == ST_RUN);
  c_dynamic_switch: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == ST_SWITCH ##1 state_reg == ST_RUN);
endmodule : hub_config_power_mode_ctrl
`default_nettype wire

// File: verilog/oc_delay_filter.sv
// per-port over-current persistence filter
// assumes synchronised sense levels and a one-cycle step pulse
`timescale 1ns/1ns
`default_nettype none
module oc_delay_filter (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // link to the controller
  oc_if.filt oc
);
  import hub_cfg_pkg::*;

  logic [1:0] step_cnt_reg [3]; // steps seen while sensing

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int p = 0; p < 3; p++) step_cnt_reg[p] <= 2'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (!oc.oc_raw[p]) begin
          step_cnt_reg[p] <= 2'h0; // glitch clears the history
        end else if (oc.tick && step_cnt_reg[p] != 2'h3) begin
          step_cnt_reg[p] <= step_cnt_reg[p] + 2'h1;
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      oc.oc_flag[p] = oc.oc_raw[p] && (step_cnt_reg[p] >= oc.delay);
    end
  end

  a_oc_not_early: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(oc.oc_raw[0]) && oc.delay != 2'h0 |-> !oc.oc_flag[0])
    else $error("over-current reported before its delay");
  c_oc_report: cover property (@(posedge clk_i) disable iff (!nrst_i)
    oc.delay != 2'h0 ##0 $rose(oc.oc_flag[0]));
endmodule : oc_delay_filter
`default_nettype wire
